// File: mpg_gpio.sv
// Top of the six-port GPIO block with its Wishbone register file
//
// What this block does
// - First port: three latched pins, each direction set by its own bit.
// - First port pull-up acts only while its pin is an input.
// - Reset puts every pin of every port in input mode.
// - Second port: eight latched pins, per-bit direction.
// - Second port pull-up acts only while its pin is an input.
// - Third port: four latched pins, per-bit direction.
// - Third port pull-up acts only while its pin is an input.
// - Fourth port: two latched pins, per-bit direction.
// - Fourth port pull-up follows its register, regardless of direction.
// - Fifth port: four latched pins, per-bit direction, no pull-up.
// - Fifth port is open-drain: zero pulls low, one releases.
// - Sixth port: four latched pins, per-bit direction.
// - Sixth port pull-up acts only while its pin is an input.
// - Third pin of first port and fourth of fifth port are optional.
// - Direction registers reset to all ones; one means input.
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module mpg_gpio
    import mpg_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // First port pins
    input wire logic [MPG_W0-1:0] first_port_in,
    output logic [MPG_W0-1:0] first_port_out,
    output logic [MPG_W0-1:0] first_port_oe,
    output logic [MPG_W0-1:0] first_port_pu,
    // Second port pins
    input wire logic [MPG_W1-1:0] second_port_in,
    output logic [MPG_W1-1:0] second_port_out,
    output logic [MPG_W1-1:0] second_port_oe,
    output logic [MPG_W1-1:0] second_port_pu,
    // Third port pins
    input wire logic [MPG_W2-1:0] third_port_in,
    output logic [MPG_W2-1:0] third_port_out,
    output logic [MPG_W2-1:0] third_port_oe,
    output logic [MPG_W2-1:0] third_port_pu,
    // Fourth port pins
    input wire logic [MPG_W3-1:0] fourth_port_in,
    output logic [MPG_W3-1:0] fourth_port_out,
    output logic [MPG_W3-1:0] fourth_port_oe,
    output logic [MPG_W3-1:0] fourth_port_pu,
    // Fifth port pins (open-drain)
    input wire logic [MPG_W4-1:0] fifth_port_in,
    output logic [MPG_W4-1:0] fifth_port_out,
    output logic [MPG_W4-1:0] fifth_port_oe,
    output logic [MPG_W4-1:0] fifth_port_pu,
    // Sixth port pins
    input wire logic [MPG_W5-1:0] sixth_port_in,
    output logic [MPG_W5-1:0] sixth_port_out,
    output logic [MPG_W5-1:0] sixth_port_oe,
    output logic [MPG_W5-1:0] sixth_port_pu,
    // Serial unit shared-pin controls
    output logic [7:0] clocked_serial_mode_ctrl,
    output logic [7:0] clocked_serial_clock_select
);

    // ------------------------------------------------------------------
    // Optional pins of the small variant
    // ------------------------------------------------------------------
    localparam logic [7:0] FIRST_MASK = LARGE_VARIANT ? 8'h07 : 8'h03;
    localparam logic [7:0] FIFTH_MASK = LARGE_VARIANT ? 8'h0f : 8'h07;

    typedef struct packed {
        logic [7:0] serial_mode;
        logic [7:0] serial_clk;
        logic [31:0] rdata;
    } mpg_top_state_type;

    mpg_top_state_type state_ff;
    mpg_top_state_type nxt_state;

    logic wr_en;
    logic rd_en;
    logic [3:0] reg_sel;
    logic [2:0] port_sel;
    logic [7:0] lat_q [MPG_NPORT];
    logic [7:0] dir_q [MPG_NPORT];
    logic [7:0] pu_q [MPG_NPORT];
    logic [7:0] rd_v [MPG_NPORT];
    logic [MPG_NPORT-1:0] wr_lat;
    logic [MPG_NPORT-1:0] wr_dir;
    logic [MPG_NPORT-1:0] wr_pu;

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    mpg_wb_slave u_wb (
        .clock(clock),
        .srst(srst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i),
        .wb_ack_o(wb_ack_o),
        .wr_en(wr_en),
        .rd_en(rd_en)
    );

    // Address split: port in bits 6:4, register in bits 3:0
    assign port_sel = wb_adr_i[6:4];
    assign reg_sel = wb_adr_i[3:0];

    // Per-port write strobes
    genvar gp;
    generate
        for (gp = 0; gp < MPG_NPORT; gp++) begin : g_wr
            logic hit;
            assign hit = wr_en && (wb_adr_i[7] == 1'b0) && (port_sel == 3'(gp));
            assign wr_lat[gp] = hit && (reg_sel == MPG_OFS_LATCH[3:0]);
            assign wr_dir[gp] = hit && (reg_sel == MPG_OFS_DIR[3:0]);
            assign wr_pu[gp] = hit && (reg_sel == MPG_OFS_PULLUP[3:0]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------
    mpg_port #(.WIDTH(MPG_W0), .PIN_MASK(FIRST_MASK)) u_p0 (
        .clock(clock), .srst(srst), .wr_latch(wr_lat[0]), .wr_dir(wr_dir[0]),
        .wr_pullup(wr_pu[0]), .wdata(wb_dat_i[7:0]), .latch_q(lat_q[0]),
        .dir_q(dir_q[0]), .pullup_q(pu_q[0]), .read_val(rd_v[0]),
        .pin_in(first_port_in), .pin_out(first_port_out), .pin_oe(first_port_oe),
        .pin_pullup(first_port_pu)
    );

    mpg_port #(.WIDTH(MPG_W1)) u_p1 (
        .clock(clock), .srst(srst), .wr_latch(wr_lat[1]), .wr_dir(wr_dir[1]),
        .wr_pullup(wr_pu[1]), .wdata(wb_dat_i[7:0]), .latch_q(lat_q[1]),
        .dir_q(dir_q[1]), .pullup_q(pu_q[1]), .read_val(rd_v[1]),
        .pin_in(second_port_in), .pin_out(second_port_out), .pin_oe(second_port_oe),
        .pin_pullup(second_port_pu)
    );

    mpg_port #(.WIDTH(MPG_W2)) u_p2 (
        .clock(clock), .srst(srst), .wr_latch(wr_lat[2]), .wr_dir(wr_dir[2]),
        .wr_pullup(wr_pu[2]), .wdata(wb_dat_i[7:0]), .latch_q(lat_q[2]),
        .dir_q(dir_q[2]), .pullup_q(pu_q[2]), .read_val(rd_v[2]),
        .pin_in(third_port_in), .pin_out(third_port_out), .pin_oe(third_port_oe),
        .pin_pullup(third_port_pu)
    );

    mpg_port #(.WIDTH(MPG_W3), .PU_INPUT_ONLY(1'b0)) u_p3 (
        .clock(clock), .srst(srst), .wr_latch(wr_lat[3]), .wr_dir(wr_dir[3]),
        .wr_pullup(wr_pu[3]), .wdata(wb_dat_i[7:0]), .latch_q(lat_q[3]),
        .dir_q(dir_q[3]), .pullup_q(pu_q[3]), .read_val(rd_v[3]),
        .pin_in(fourth_port_in), .pin_out(fourth_port_out), .pin_oe(fourth_port_oe),
        .pin_pullup(fourth_port_pu)
    );

    mpg_port #(.WIDTH(MPG_W4), .OPEN_DRAIN(1'b1), .HAS_PULLUP(1'b0),
               .PIN_MASK(FIFTH_MASK)) u_p4 (
        .clock(clock), .srst(srst), .wr_latch(wr_lat[4]), .wr_dir(wr_dir[4]),
        .wr_pullup(wr_pu[4]), .wdata(wb_dat_i[7:0]), .latch_q(lat_q[4]),
        .dir_q(dir_q[4]), .pullup_q(pu_q[4]), .read_val(rd_v[4]),
        .pin_in(fifth_port_in), .pin_out(fifth_port_out), .pin_oe(fifth_port_oe),
        .pin_pullup(fifth_port_pu)
    );

    mpg_port #(.WIDTH(MPG_W5)) u_p5 (
        .clock(clock), .srst(srst), .wr_latch(wr_lat[5]), .wr_dir(wr_dir[5]),
        .wr_pullup(wr_pu[5]), .wdata(wb_dat_i[7:0]), .latch_q(lat_q[5]),
        .dir_q(dir_q[5]), .pullup_q(pu_q[5]), .read_val(rd_v[5]),
        .pin_in(sixth_port_in), .pin_out(sixth_port_out), .pin_oe(sixth_port_oe),
        .pin_pullup(sixth_port_pu)
    );

    // ------------------------------------------------------------------
    // Serial controls and read data
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] rv;
        rv = 8'h00;
        nxt_state = state_ff;
        if (wr_en && wb_adr_i == MPG_OFS_SERIAL_MODE) begin
            nxt_state.serial_mode = wb_dat_i[7:0];
        end
        if (wr_en && wb_adr_i == MPG_OFS_SERIAL_CLK) begin
            nxt_state.serial_clk = wb_dat_i[7:0];
        end
        // Unmapped addresses read as zero
        if (wb_adr_i[7] == 1'b0 && port_sel < 3'(MPG_NPORT)) begin
            unique case (reg_sel)
                MPG_OFS_LATCH[3:0]: rv = rd_v[port_sel];
                MPG_OFS_DIR[3:0]: rv = dir_q[port_sel];
                MPG_OFS_PULLUP[3:0]: rv = pu_q[port_sel];
                default: rv = 8'h00;
            endcase
        end
        if (wb_adr_i == MPG_OFS_SERIAL_MODE) begin
            rv = state_ff.serial_mode;
        end
        if (wb_adr_i == MPG_OFS_SERIAL_CLK) begin
            rv = state_ff.serial_clk;
        end
        // Read data sampled in the request cycle, presented with ack
        nxt_state.rdata = (wb_cyc_i && wb_stb_i && !wb_ack_o) ? {24'h000000, rv} : 32'h0;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff.serial_mode <= MPG_SERIAL_RESET;
            state_ff.serial_clk <= MPG_SERIAL_RESET;
            state_ff.rdata <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wb_dat_o = state_ff.rdata;
    assign clocked_serial_mode_ctrl = state_ff.serial_mode;
    assign clocked_serial_clock_select = state_ff.serial_clk;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // A direction write of ones makes the second port fully undriven
    a_dir_input: assert property (@(posedge clock) disable iff (srst)
        (wr_dir[1] && wb_dat_i[7:0] == 8'hff) |=> (second_port_oe == 8'h00))
        else $error("Second port driven after input select");
    // Fourth port pull-up tracks register regardless of direction
    a_pu4_plain: assert property (@(posedge clock) disable iff (srst)
        fourth_port_pu == pu_q[3][MPG_W3-1:0])
        else $error("Fourth port pull-up gated");
    // Fifth port never drives a pull-up
    a_pu5_none: assert property (@(posedge clock) disable iff (srst)
        fifth_port_pu == '0)
        else $error("Fifth port pull-up active");
    // Optional pins stay undriven in the small variant
    a_opt_pins: assert property (@(posedge clock) disable iff (srst)
        !LARGE_VARIANT |-> (!first_port_oe[2] && !fifth_port_oe[3]))
        else $error("Absent pin driven");
    // Third and sixth port direction registers read all ones after reset
    a_dir_reset: assert property (@(posedge clock)
        srst |=> (dir_q[2][MPG_W2-1:0] == 4'hf && dir_q[5][MPG_W5-1:0] == 4'hf))
        else $error("Direction reset not all ones");

endmodule : mpg_gpio

// File: mpg_pkg.sv
// Package of register offsets, widths and reset values for the GPIO block
package mpg_pkg;

    // ------------------------------------------------------------------
    // Port widths
    // ------------------------------------------------------------------
    localparam int MPG_NPORT = 6;
    localparam int MPG_W0 = 3;
    localparam int MPG_W1 = 8;
    localparam int MPG_W2 = 4;
    localparam int MPG_W3 = 2;
    localparam int MPG_W4 = 4;
    localparam int MPG_W5 = 4;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses), three registers per port
    // ------------------------------------------------------------------
    localparam logic [7:0] MPG_OFS_LATCH = 8'h00;
    localparam logic [7:0] MPG_OFS_DIR = 8'h04;
    localparam logic [7:0] MPG_OFS_PULLUP = 8'h08;
    localparam logic [7:0] MPG_PORT_STRIDE = 8'h10;
    localparam logic [7:0] MPG_OFS_SERIAL_MODE = 8'h60;
    localparam logic [7:0] MPG_OFS_SERIAL_CLK = 8'h64;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] MPG_DIR_RESET = 8'hff;
    localparam logic [7:0] MPG_LATCH_RESET = 8'h00;
    localparam logic [7:0] MPG_PULLUP_RESET = 8'h00;
    localparam logic [7:0] MPG_SERIAL_RESET = 8'h00;

    // Bus slave state
    typedef enum logic {MPG_IDLE, MPG_ACK} mpg_bus_state_type;

endpackage : mpg_pkg

// File: mpg_port.sv
// One GPIO port: latch, direction, pull-up and pin drive for up to 8 pins
`timescale 1ns/1ps
module mpg_port
    import mpg_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter bit OPEN_DRAIN = 1'b0,
    parameter bit HAS_PULLUP = 1'b1,
    parameter bit PU_INPUT_ONLY = 1'b1,
    parameter logic [7:0] PIN_MASK = 8'hff
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register writes
    input wire logic wr_latch,
    input wire logic wr_dir,
    input wire logic wr_pullup,
    input wire logic [7:0] wdata,
    // Register read values
    output logic [7:0] latch_q,
    output logic [7:0] dir_q,
    output logic [7:0] pullup_q,
    output logic [7:0] read_val,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_pullup
);

    typedef struct packed {
        logic [WIDTH-1:0] latch;
        logic [WIDTH-1:0] dir;
        logic [WIDTH-1:0] pu;
    } mpg_port_state_type;

    mpg_port_state_type state_ff;
    mpg_port_state_type nxt_state;

    // ------------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (wr_latch) begin
            nxt_state.latch = wdata[WIDTH-1:0] & PIN_MASK[WIDTH-1:0];
        end
        if (wr_dir) begin
            nxt_state.dir = wdata[WIDTH-1:0] | ~PIN_MASK[WIDTH-1:0];
        end
        if (wr_pullup && HAS_PULLUP) begin
            nxt_state.pu = wdata[WIDTH-1:0] & PIN_MASK[WIDTH-1:0];
        end
    end

    // Reset puts every pin in input mode
    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff.latch <= MPG_LATCH_RESET[WIDTH-1:0];
            state_ff.dir <= MPG_DIR_RESET[WIDTH-1:0];
            state_ff.pu <= MPG_PULLUP_RESET[WIDTH-1:0];
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive, one slice per bit
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            logic is_out;
            assign is_out = ~state_ff.dir[gi] & PIN_MASK[gi];
            if (OPEN_DRAIN) begin : g_od
                // Only a latched zero pulls the pin low
                assign pin_out[gi] = 1'b0;
                assign pin_oe[gi] = is_out & ~state_ff.latch[gi];
            end else begin : g_pp
                assign pin_out[gi] = state_ff.latch[gi];
                assign pin_oe[gi] = is_out;
            end
            if (!HAS_PULLUP) begin : g_npu
                assign pin_pullup[gi] = 1'b0;
            end else if (PU_INPUT_ONLY) begin : g_pui
                assign pin_pullup[gi] = state_ff.pu[gi] & ~is_out;
            end else begin : g_pua
                assign pin_pullup[gi] = state_ff.pu[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read values, zero-extended
    // ------------------------------------------------------------------
    always_comb begin
        latch_q = '0;
        dir_q = '0;
        pullup_q = '0;
        read_val = '0;
        latch_q[WIDTH-1:0] = state_ff.latch;
        dir_q[WIDTH-1:0] = state_ff.dir;
        pullup_q[WIDTH-1:0] = state_ff.pu;
        // Input pins show the pin, output pins the latch
        read_val[WIDTH-1:0] = ((state_ff.dir & pin_in) | (~state_ff.dir & state_ff.latch))
                              & PIN_MASK[WIDTH-1:0];
    end

    // Direction bits all one keep every pin undriven
    a_input_undriven: assert property (@(posedge clock) disable iff (srst)
        (state_ff.dir == {WIDTH{1'b1}}) |-> (pin_oe == '0))
        else $error("Input-mode pin is driven");
    // Reset releases every pin at the next edge
    a_reset_input: assert property (@(posedge clock)
        srst |=> (pin_oe == '0))
        else $error("Pin driven after reset");
    // Pull-up never active on a driven pin of a qualified port
    a_pullup_gate: assert property (@(posedge clock) disable iff (srst)
        (HAS_PULLUP && PU_INPUT_ONLY) |-> ((pin_pullup & ~state_ff.dir) == '0))
        else $error("Pull-up on output pin");
    // Open-drain never drives high
    a_od_no_high: assert property (@(posedge clock) disable iff (srst)
        OPEN_DRAIN |-> ((pin_oe & pin_out) == '0))
        else $error("Open-drain pin driven high");
    // A latch write shows in the latch a cycle later
    a_latch_write: assert property (@(posedge clock) disable iff (srst)
        wr_latch |=> (state_ff.latch == ($past(wdata[WIDTH-1:0]) & PIN_MASK[WIDTH-1:0])))
        else $error("Latch write lost");

endmodule : mpg_port

// File: mpg_wb_slave.sv
// Classic Wishbone slave front end: one-wait-state ack and write strobe
`timescale 1ns/1ps
module mpg_wb_slave
    import mpg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Wishbone request
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    // Decoded access
    output logic wr_en,
    output logic rd_en
);

    typedef struct packed {
        mpg_bus_state_type st;
    } mpg_wb_state_type;

    mpg_wb_state_type state_ff;
    mpg_wb_state_type nxt_state;

    // Ack one cycle after the request, dropped the cycle after
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff.st)
            MPG_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    nxt_state.st = MPG_ACK;
                end
            end
            MPG_ACK: begin
                nxt_state.st = MPG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff.st <= MPG_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wb_ack_o = (state_ff.st == MPG_ACK);
    // Write takes effect at the acking edge, only with byte lane 0
    assign wr_en = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    assign rd_en = wb_ack_o & wb_cyc_i & wb_stb_i & ~wb_we_i;

    // Every request is acked exactly one cycle later
    a_ack_timing: assert property (@(posedge clock) disable iff (srst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("Ack not given one cycle after request");
    // Ack never stands two cycles
    a_ack_single: assert property (@(posedge clock) disable iff (srst)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held two cycles");

endmodule : mpg_wb_slave

// File: mpg_board.sv
// Board model that resolves each package pin of the GPIO block
`timescale 1ns/1ps
module mpg_board #(
    parameter int WIDTH = 32
) (
    // Block drive
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] pin_pu,
    // Board source and resolved level
    input wire logic [WIDTH-1:0] ext_level,
    output logic [WIDTH-1:0] pin_level
);
    // A driven pin wins; a released pin goes to the pull-up, else to the board source
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & pin_pu) | (~pin_oe & ~pin_pu & ext_level);
endmodule : mpg_board

// File: mpg_gpio_tb_top.sv
// Self-checking testbench of the six-port GPIO block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module mpg_gpio_tb_top;
    import mpg_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int BASE [6] = '{0, 3, 11, 15, 17, 21};
    localparam int WID [6] = '{MPG_W0, MPG_W1, MPG_W2, MPG_W3, MPG_W4, MPG_W5};
    logic clock = 0, srst = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, ext_all = 32'h0;
    wire [31:0] out_v, oe_v, pu_v, lvl;
    wire [2:0] sm_oe0;
    wire [3:0] sm_oe4;
    logic ack;
    logic [7:0] smode, sclk;
    int fail_count = 0, n_checks = 0;
    // Clock of 50 ns
    always #25 clock = ~clock;
    // Unused top bits of the pin vectors
    assign {out_v[31:25], oe_v[31:25], pu_v[31:25]} = 21'h0;
    mpg_board #(.WIDTH(32)) i_mpg_board (.pin_out(out_v), .pin_oe(oe_v), .pin_pu(pu_v),
        .ext_level(ext_all), .pin_level(lvl));
    mpg_gpio i_mpg_gpio (.clock(clock), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .clocked_serial_mode_ctrl(smode), .clocked_serial_clock_select(sclk),
        .first_port_in(lvl[2:0]), .first_port_out(out_v[2:0]),
        .first_port_oe(oe_v[2:0]), .first_port_pu(pu_v[2:0]),
        .second_port_in(lvl[10:3]), .second_port_out(out_v[10:3]),
        .second_port_oe(oe_v[10:3]), .second_port_pu(pu_v[10:3]),
        .third_port_in(lvl[14:11]), .third_port_out(out_v[14:11]),
        .third_port_oe(oe_v[14:11]), .third_port_pu(pu_v[14:11]),
        .fourth_port_in(lvl[16:15]), .fourth_port_out(out_v[16:15]),
        .fourth_port_oe(oe_v[16:15]), .fourth_port_pu(pu_v[16:15]),
        .fifth_port_in(lvl[20:17]), .fifth_port_out(out_v[20:17]),
        .fifth_port_oe(oe_v[20:17]), .fifth_port_pu(pu_v[20:17]),
        .sixth_port_in(lvl[24:21]), .sixth_port_out(out_v[24:21]),
        .sixth_port_oe(oe_v[24:21]), .sixth_port_pu(pu_v[24:21]));
    // Small variant on the same bus, to watch its absent pins
    mpg_gpio #(.LARGE_VARIANT(1'b0)) i_mpg_gpio_small (.clock(clock), .srst(srst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(), .clocked_serial_mode_ctrl(),
        .clocked_serial_clock_select(), .first_port_in(lvl[2:0]), .first_port_out(),
        .first_port_oe(sm_oe0), .first_port_pu(), .second_port_in(lvl[10:3]),
        .second_port_out(), .second_port_oe(), .second_port_pu(),
        .third_port_in(lvl[14:11]), .third_port_out(), .third_port_oe(), .third_port_pu(),
        .fourth_port_in(lvl[16:15]), .fourth_port_out(), .fourth_port_oe(),
        .fourth_port_pu(), .fifth_port_in(lvl[20:17]), .fifth_port_out(),
        .fifth_port_oe(sm_oe4), .fifth_port_pu(), .sixth_port_in(lvl[24:21]),
        .sixth_port_out(), .sixth_port_oe(), .sixth_port_pu());
    // ------------------------------------------------------------------
    // Bus and reset tasks
    // ------------------------------------------------------------------
    // One classic cycle; holds the request until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
            input logic [3:0] s, output logic [7:0] q);
        int t;
        t = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'h0, d};
        do begin
            @(posedge clock);
            t++;
        end while (ack !== 1'b1 && t < 40);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (t >= 40) fail_count++;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, 4'hf, q);
    endtask : wr
    task automatic do_reset();
        @(posedge clock);
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
    endtask : do_reset
    task automatic conclude();
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Pins idle as inputs with directions all ones; serial controls left at default
    task automatic reset_case();
        logic [7:0] q;
        @(negedge clock);
        `CHK("oe", 32'h0, oe_v)
        `CHK("pu", 32'h0, pu_v)
        for (int n = 0; n < 6; n++) begin
            xfer(1'b0, 8'(n * 16 + 4), 8'h00, 4'h0, q);
            `CHK("dir", 8'((1 << WID[n]) - 1), q & 8'((1 << WID[n]) - 1))
        end
        xfer(1'b0, MPG_OFS_SERIAL_MODE, 8'h00, 4'h0, q);
        `CHK("serial mode", 8'h00, q)
        `CHK("serial clk", 8'h00, sclk)
        `CHK("serial mode pin", 8'h00, smode)
    endtask : reset_case
    // Program one port and judge drive, pull-up and read-back
    task automatic port_case(input int n, input logic [7:0] d, l, p, e);
        logic [7:0] q, m, oe, pu, lv;
        int b;
        b = BASE[n];
        m = 8'((1 << WID[n]) - 1);
        ext_all[b +: 8] <= e;
        wr(8'(n * 16), l);
        wr(8'(n * 16 + 4), d);
        wr(8'(n * 16 + 8), p);
        oe = ~d & m & ((n == 4) ? ~l : 8'hff);
        pu = (n == 4) ? 8'h00 : (n == 3) ? p & m : p & d & m;
        lv = (oe & ((n == 4) ? 8'h00 : l)) | (~oe & pu) | (~oe & ~pu & e);
        @(negedge clock);
        `CHK("oe", oe, oe_v[b +: 8] & m)
        `CHK("pu", pu, pu_v[b +: 8] & m)
        `CHK("out", (n == 4) ? 8'h00 : l & m, out_v[b +: 8] & m)
        xfer(1'b0, 8'(n * 16), 8'h00, 4'h0, q);
        `CHK("data", ((d & lv) | (~d & l)) & m, q & m)
        xfer(1'b0, 8'(n * 16 + 8), 8'h00, 4'h0, q);
        `CHK("pullup reg", (n == 4) ? 8'h00 : p & m, q & m)
    endtask : port_case
    // Masked write and unmapped place leave state untouched
    task automatic misc_case();
        logic [7:0] q;
        xfer(1'b1, 8'h10, 8'h77, 4'h0, q);
        wr(8'h70, 8'hff);
        xfer(1'b0, 8'h70, 8'h00, 4'h0, q);
        `CHK("unmapped", 8'h00, q)
        @(negedge clock);
        `CHK("masked write", 8'hc3, out_v[10:3])
        // Serial controls take a write, then go back to default before pin use
        wr(MPG_OFS_SERIAL_MODE, 8'ha5);
        wr(MPG_OFS_SERIAL_CLK, 8'h5a);
        xfer(1'b0, MPG_OFS_SERIAL_CLK, 8'h00, 4'h0, q);
        `CHK("serial clk rd", 8'h5a, q)
        `CHK("serial clk pin", 8'h5a, sclk)
        `CHK("serial mode pin", 8'ha5, smode)
        wr(MPG_OFS_SERIAL_MODE, MPG_SERIAL_RESET);
        wr(MPG_OFS_SERIAL_CLK, MPG_SERIAL_RESET);
        // All pins of first and fifth port driven low; absent pins stay released
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h00);
        wr(8'h40, 8'h00);
        wr(8'h44, 8'h00);
        @(negedge clock);
        `CHK("opt pins large", 7'h7f, {oe_v[20:17], oe_v[2:0]})
        `CHK("opt pins small", 7'h3b, {sm_oe4, sm_oe0})
    endtask : misc_case
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        reset_case();
        for (int n = 0; n < 6; n++) begin
            port_case(n, 8'ha5, 8'h3c, 8'hff, 8'hff);
            port_case(n, 8'h5a, 8'hc3, 8'h0f, 8'h00);
            port_case(n, 8'hff, 8'hc3, 8'h55, 8'h0f);
        end
        misc_case();
        do_reset();
        reset_case();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        conclude();
    end
endmodule : mpg_gpio_tb_top
